/* File: hw/subword_align_pkg.sv */
// Constants, field layout and carrier types for the sub-word alignment block.
// Assumes one processor clock and an AXI4-Lite master for configuration.
// Summary of operation
// - Hardware load selects byte or half-word lane
// - Selected lane lands right-justified in result
// - Sign select low zero-fills upper bits
// - Sign select high copies lane sign bit
// - Hardware store replicates low byte/half everywhere
// - Sign select never alters store data
// - Enable and sign set pointer to ~order unless frozen or coprocessor
// - Sub-word accesses still work while frozen
// - Size 001 is byte, 010 half-word
// - Order 0 makes lane 00 most significant
// - Half-word chosen by address bit 1 only
// - Reset clears the hardware sub-word enable
package subword_align_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          AXI_ADDR_W   = 4;
    localparam logic [3:0]  OFS_CONFIG   = 4'h0;
    localparam logic [3:0]  OFS_STATUS   = 4'h4;
    localparam int          CFG_EN_BIT   = 0;  // hw_subword_enable
    localparam int          CFG_ORD_BIT  = 1;  // lane_order_bit
    localparam int          CFG_FZ_BIT   = 2;  // status_freeze
    localparam logic [2:0]  CFG_RESET    = 3'h0;
    localparam int          STAT_LP_LSB  = 0;  // lane_pointer_field [1:0]
    localparam int          STAT_SZ_LSB  = 4;  // last access size [6:4]
    localparam int          STAT_LD_BIT  = 8;  // last access was a load
    localparam logic [1:0]  LP_RESET     = 2'h0;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;

    // ------------------------------------------------------------
    // Access size codes
    // ------------------------------------------------------------
    localparam logic [2:0]  SIZE_WORD    = 3'h0;
    localparam logic [2:0]  SIZE_BYTE    = 3'h1;
    localparam logic [2:0]  SIZE_HALF    = 3'h2;

    // One load or store presented by the pipeline
    typedef struct packed {
        logic        is_load;
        logic        is_coproc;
        logic [2:0]  access_size_option;
        logic        sign_select;
        logic [1:0]  addr_lo;
        logic [31:0] store_data;
    } acc_req_s;

endpackage : subword_align_pkg

/* File: hw/lane_extract.sv */
// Lane selection and extension of a returned word for sub-word loads.
// Assumes the caller has already decided that a sub-word load applies.
`timescale 1ns/100ps
module lane_extract (
    // Returned word and access shape
    input  wire logic [31:0] i_word,
    input  wire logic [2:0]  i_size,
    input  wire logic [1:0]  i_addr_lo,
    input  wire logic        i_lane_order,
    input  wire logic        i_sign_select,
    // Aligned result
    output logic      [31:0] o_result
);

    // ------------------------------------------------------------
    // Lane choice
    // ------------------------------------------------------------
    logic [1:0]  byte_lane;
    logic        half_hi;
    logic [7:0]  sel_byte;
    logic [15:0] sel_half;
    logic        is_byte;

    // Order 0 counts lanes from the top of the word, so invert index
    assign byte_lane = i_lane_order ? i_addr_lo : ~i_addr_lo;
    assign half_hi   = i_lane_order ? i_addr_lo[1] : ~i_addr_lo[1];
    assign sel_byte  = i_word[{byte_lane, 3'h0} +: 8];
    assign sel_half  = half_hi ? i_word[31:16] : i_word[15:0];
    assign is_byte   = (i_size == subword_align_pkg::SIZE_BYTE);

    // Right-justify, then zero or sign fill the upper part
    assign o_result  = is_byte
        ? {{24{i_sign_select & sel_byte[7]}}, sel_byte}
        : {{16{i_sign_select & sel_half[15]}}, sel_half};

endmodule : lane_extract

/* File: hw/subword_load_store_align.sv */
// Load/store alignment for hardware byte and half-word accesses,
// with an AXI4-Lite slave holding configuration and status.
// Assumes the pipeline and memory share i_clk_sys; memory returns
// a full 32-bit word on every read and decodes its own strobes.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module subword_load_store_align (
    // Clock and reset
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_sys_rst,
    // AXI4-Lite write address / data / response
    input  wire logic                         i_s_axi_awvalid,
    output logic                              o_s_axi_awready,
    input  wire logic [3:0]                   i_s_axi_awaddr,
    input  wire logic                         i_s_axi_wvalid,
    output logic                              o_s_axi_wready,
    input  wire logic [31:0]                  i_s_axi_wdata,
    input  wire logic [3:0]                   i_s_axi_wstrb,
    output logic                              o_s_axi_bvalid,
    input  wire logic                         i_s_axi_bready,
    output logic      [1:0]                   o_s_axi_bresp,
    // AXI4-Lite read address / data
    input  wire logic                         i_s_axi_arvalid,
    output logic                              o_s_axi_arready,
    input  wire logic [3:0]                   i_s_axi_araddr,
    output logic                              o_s_axi_rvalid,
    input  wire logic                         i_s_axi_rready,
    output logic      [31:0]                  o_s_axi_rdata,
    output logic      [1:0]                   o_s_axi_rresp,
    // Access from the pipeline
    input  wire logic                         i_req_valid,
    input  wire subword_align_pkg::acc_req_s  i_req,
    input  wire logic [31:0]                  i_load_word,
    // Aligned results
    output logic                              o_rsp_valid,
    output logic      [31:0]                  o_load_result,
    output logic      [31:0]                  o_store_word,
    output logic      [2:0]                   o_access_size_outputs,
    output logic      [1:0]                   o_addr_lo,
    output logic      [1:0]                   o_lane_pointer_field
);

    // ------------------------------------------------------------
    // Configuration and status state
    // ------------------------------------------------------------
    logic [2:0]  cfg_q;
    logic [1:0]  lp_q;
    logic [2:0]  last_size_q;
    logic        last_load_q;
    logic        en;
    logic        ord;
    logic        frz;

    assign en  = cfg_q[subword_align_pkg::CFG_EN_BIT];
    assign ord = cfg_q[subword_align_pkg::CFG_ORD_BIT];
    assign frz = cfg_q[subword_align_pkg::CFG_FZ_BIT];

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic        aw_got_q;
    logic        w_got_q;
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        aw_hs;
    logic        w_hs;
    logic        wr_fire;
    logic        wr_cfg;
    logic        wr_hit;

    // Address and data latch independently, so either may come first
    assign o_s_axi_awready = !aw_got_q && !bvalid_q;
    assign o_s_axi_wready  = !w_got_q && !bvalid_q;
    assign aw_hs   = i_s_axi_awvalid && o_s_axi_awready;
    assign w_hs    = i_s_axi_wvalid && o_s_axi_wready;
    assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
    assign wr_cfg  = awaddr_q[3:2] == subword_align_pkg::OFS_CONFIG[3:2];
    assign wr_hit  = wr_cfg
        || (awaddr_q[3:2] == subword_align_pkg::OFS_STATUS[3:2]);
    assign o_s_axi_bvalid = bvalid_q;
    assign o_s_axi_bresp  = bresp_q;

    // Capture the write halves
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
        end else begin
            aw_got_q <= wr_fire ? 1'b0 : (aw_got_q | aw_hs);
            w_got_q  <= wr_fire ? 1'b0 : (w_got_q | w_hs);
            if (aw_hs) begin
                awaddr_q <= i_s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= i_s_axi_wdata;
                wstrb_q <= i_s_axi_wstrb;
            end
        end
    end

    // Response one cycle after both halves are held
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= subword_align_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? subword_align_pkg::RESP_OKAY
                               : subword_align_pkg::RESP_DECERR;
        end else if (i_s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Config register; reset leaves the enable off until software sets it
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cfg_q <= subword_align_pkg::CFG_RESET;
        end else if (wr_fire && wr_cfg && wstrb_q[0]) begin
            cfg_q <= wdata_q[2:0];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        ar_hs;
    logic        rd_cfg;
    logic        rd_stat;
    logic [31:0] stat_word;

    assign o_s_axi_arready = !rvalid_q;
    assign ar_hs   = i_s_axi_arvalid && o_s_axi_arready;
    assign rd_cfg  = i_s_axi_araddr[3:2] == subword_align_pkg::OFS_CONFIG[3:2];
    assign rd_stat = i_s_axi_araddr[3:2] == subword_align_pkg::OFS_STATUS[3:2];
    assign stat_word = {23'h0, last_load_q, 1'b0, last_size_q, 2'h0, lp_q};
    assign o_s_axi_rvalid = rvalid_q;
    assign o_s_axi_rdata  = rdata_q;
    assign o_s_axi_rresp  = rresp_q;

    // Read data is registered; unmapped words read zero with DECERR
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= subword_align_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_cfg ? {29'h0, cfg_q} : (rd_stat ? stat_word : 32'h0);
            rresp_q  <= (rd_cfg || rd_stat) ? subword_align_pkg::RESP_OKAY
                                            : subword_align_pkg::RESP_DECERR;
        end else if (i_s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Datapath decode
    // ------------------------------------------------------------
    logic        sub_sz;
    logic        hw_sub;
    logic        lp_set;
    logic [31:0] ext_word;
    logic [31:0] rep_word;
    logic [31:0] ld_d;
    logic [31:0] st_d;

    // Only byte and half codes are sub-word; coprocessor moves skip it
    assign sub_sz = (i_req.access_size_option == subword_align_pkg::SIZE_BYTE)
        || (i_req.access_size_option == subword_align_pkg::SIZE_HALF);
    assign hw_sub = en && sub_sz && !i_req.is_coproc;
    // Pointer update does not touch the access itself; freeze blocks it
    assign lp_set = i_req_valid && en && i_req.sign_select
        && !i_req.is_coproc && !frz;

    lane_extract u_lane_extract (
        .i_word        (i_load_word),
        .i_size        (i_req.access_size_option),
        .i_addr_lo     (i_req.addr_lo),
        .i_lane_order  (ord),
        .i_sign_select (i_req.sign_select),
        .o_result      (ext_word)
    );

    // Store copies ignore sign_select entirely
    assign rep_word = (i_req.access_size_option == subword_align_pkg::SIZE_BYTE)
        ? {4{i_req.store_data[7:0]}}
        : {2{i_req.store_data[15:0]}};
    assign ld_d = hw_sub ? ext_word : i_load_word;
    assign st_d = hw_sub ? rep_word : i_req.store_data;

    // ------------------------------------------------------------
    // Registered results
    // ------------------------------------------------------------
    // Size and address go out so the memory side can build strobes
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rsp_valid           <= 1'b0;
            o_load_result         <= 32'h0;
            o_store_word          <= 32'h0;
            o_access_size_outputs <= subword_align_pkg::SIZE_WORD;
            o_addr_lo             <= 2'h0;
        end else begin
            o_rsp_valid <= i_req_valid;
            if (i_req_valid) begin
                o_load_result         <= ld_d;
                o_store_word          <= st_d;
                o_access_size_outputs <= i_req.access_size_option;
                o_addr_lo             <= i_req.addr_lo;
            end
        end
    end

    // Pointer and last-access status
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            lp_q        <= subword_align_pkg::LP_RESET;
            last_size_q <= subword_align_pkg::SIZE_WORD;
            last_load_q <= 1'b0;
        end else begin
            if (lp_set) begin
                lp_q <= {2{~ord}};
            end
            if (i_req_valid) begin
                last_size_q <= i_req.access_size_option;
                last_load_q <= i_req.is_load;
            end
        end
    end
    assign o_lane_pointer_field = lp_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_sub_load;
        i_req_valid && i_req.is_load && en && !i_req.is_coproc;
    endsequence

    sequence s_byte_load;
        s_sub_load and
        (i_req.access_size_option == subword_align_pkg::SIZE_BYTE);
    endsequence

    property p_reset_clears_en;
        @(posedge i_clk_sys) i_sys_rst |=> !en;
    endproperty
    a_reset_clears_en: assert property (p_reset_clears_en)
        else $error("enable not cleared by reset");

    property p_zero_fill;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (s_byte_load and !i_req.sign_select) |=> o_load_result[31:8] == 24'h0;
    endproperty
    a_zero_fill: assert property (p_zero_fill)
        else $error("byte load not zero filled");

    property p_sign_fill;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (s_byte_load and i_req.sign_select)
        |=> o_load_result[31:8] == {24{o_load_result[7]}};
    endproperty
    a_sign_fill: assert property (p_sign_fill)
        else $error("byte load not sign filled");

    property p_msb_lane;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (s_byte_load and !ord && i_req.addr_lo == 2'h0)
        |=> o_load_result[7:0] == $past(i_load_word[31:24]);
    endproperty
    a_msb_lane: assert property (p_msb_lane)
        else $error("lane 00 did not pick top byte");

    property p_half_rep;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_req_valid && en && !i_req.is_coproc
         && i_req.access_size_option == subword_align_pkg::SIZE_HALF)
        |=> o_store_word == {2{$past(i_req.store_data[15:0])}};
    endproperty
    a_half_rep: assert property (p_half_rep)
        else $error("half-word not replicated");

    property p_word_pass;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_req_valid && (i_req.is_coproc
         || i_req.access_size_option == subword_align_pkg::SIZE_WORD))
        |=> o_load_result == $past(i_load_word)
            && o_store_word == $past(i_req.store_data);
    endproperty
    a_word_pass: assert property (p_word_pass)
        else $error("word or coprocessor access altered");

    property p_ptr_set;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (i_req_valid && en && i_req.sign_select && !i_req.is_coproc && !frz)
        |=> lp_q == {2{~$past(ord)}};
    endproperty
    a_ptr_set: assert property (p_ptr_set)
        else $error("pointer not set to inverse order");

    property p_frozen_hold;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        frz ##1 frz |-> $stable(lp_q);
    endproperty
    a_frozen_hold: assert property (p_frozen_hold)
        else $error("pointer moved while frozen");

    property p_bresp_hold;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        (bvalid_q && !i_s_axi_bready) |=> bvalid_q && $stable(bresp_q);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped early");

endmodule : subword_load_store_align

/* File: tb/lane_mem_model.sv */
// Far-side memory model: one word with byte lane write strobes.
// Assumes writes are qualified outside and reads are combinational.
`timescale 1ns/100ps
module lane_mem_model (
    // Clock
    input  wire logic        i_clk,
    // Write side
    input  wire logic        i_we,
    input  wire logic        i_strobes,
    input  wire logic [2:0]  i_size,
    input  wire logic [1:0]  i_addr_lo,
    input  wire logic        i_order,
    input  wire logic [31:0] i_wdata,
    // Read side
    output logic      [31:0] o_rdata
);
    logic [31:0] mem_q = 32'h0;
    logic [3:0]  strb;
    logic [1:0]  bsel;
    logic        hsel;

    // Lane strobes from size code, low address and system byte order
    assign bsel = i_order ? i_addr_lo : ~i_addr_lo;
    assign hsel = i_order ? i_addr_lo[1] : ~i_addr_lo[1];
    // A word-only system (enable low) has no lane strobes at all
    assign strb = !i_strobes ? 4'hF :
                  (i_size == 3'h1) ? (4'h1 << bsel) :
                  (i_size == 3'h2) ? (hsel ? 4'hC : 4'h3) : 4'hF;
    // Always a whole word back, whatever width was asked for
    assign o_rdata = mem_q;

    // Only the strobed lanes change
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (i_we && strb[k]) mem_q[8*k +: 8] <= i_wdata[8*k +: 8];
        end
    end
endmodule : lane_mem_model

/* File: tb/subword_load_store_align_test.sv */
// Self-checking bench for the sub-word alignment block.
// Assumes the lane memory model on the far side and AXI4-Lite config.
`timescale 1ns/100ps
module subword_load_store_align_test;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, rqv = 0;
    logic [3:0]  awa = 4'h0, ara = 4'h0;
    logic [31:0] wd = 32'h0, rd, lres, sw, lw, r32, mem_e = 32'h0, sd = 32'h5A420A65;
    logic        awr, wr, bv, arr, rv, rspv, st = 0, en = 0, ord = 0, fz = 0, lld = 0;
    logic [1:0]  br, rr, lp, alo, resp, lp_e = 2'h0;
    logic [2:0]  aso, lsz = 3'h0;
    subword_align_pkg::acc_req_s rq = '0;
    int          fails = 0, samples_checked = 0;

    always #50 clk = ~clk;

    // -------------------------------------------------------------
    // Design and far side
    // -------------------------------------------------------------
    subword_load_store_align i_subword_load_store_align (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
        .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .i_s_axi_wdata(wd),
        .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br),
        .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
        .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr),
        .i_req_valid(rqv), .i_req(rq), .i_load_word(lw), .o_rsp_valid(rspv),
        .o_load_result(lres), .o_store_word(sw), .o_access_size_outputs(aso),
        .o_addr_lo(alo), .o_lane_pointer_field(lp));
    lane_mem_model i_lane_mem_model (.i_clk(clk), .i_we(rspv && st), .i_strobes(en),
        .i_size(aso), .i_addr_lo(alo), .i_order(ord), .i_wdata(sw), .o_rdata(lw));

    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic test_done;
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // Write: both halves offered together, each dropped once taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awv <= 1; wv <= 1; awa <= a; wd <= d;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (bv !== 1'b1);
        // Accept the response one cycle late so it must stand meanwhile
        bry <= 1;
        @(posedge clk);
        r = br;
        bry <= 0;
    endtask : axw

    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        arv <= 1; ara <= a; rry <= 1;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (rv !== 1'b1);
        d = rd; r = rr;
        rry <= 0;
    endtask : axr

    task automatic cfg(input logic e, input logic o, input logic f);
        axw(subword_align_pkg::OFS_CONFIG, {29'h0, f, o, e}, resp);
        chk({30'h0, resp}, {30'h0, subword_align_pkg::RESP_OKAY});
        en = e; ord = o; fz = f;
    endtask : cfg

    // One access, with the reference result worked out beforehand
    task automatic acc(input logic ld, cp, input logic [2:0] sz, input logic sg,
                       input logic [1:0] a, input logic [31:0] d);
        logic [31:0] el, es;
        logic [1:0]  sel;
        logic [15:0] h;
        logic [7:0]  b;
        logic        sub, hs, byt, hlf;
        byt = (sz == 3'h1);
        hlf = (sz == 3'h2);
        sub = en && !cp && (byt || hlf);
        sel = ord ? a : ~a;
        hs  = ord ? a[1] : ~a[1];
        b   = mem_e[8*sel +: 8];
        h   = hs ? mem_e[31:16] : mem_e[15:0];
        el  = mem_e;
        es  = d;
        if (sub && byt) el = sg ? {{24{b[7]}}, b} : {24'h0, b};
        if (sub && hlf) el = sg ? {{16{h[15]}}, h} : {16'h0, h};
        if (sub && byt) es = {4{d[7:0]}};
        if (sub && hlf) es = {2{d[15:0]}};
        if (en && sg && !cp && !fz) lp_e = {~ord, ~ord};
        lsz = sz; lld = ld;
        @(posedge clk);
        rqv <= 1; rq <= '{ld, cp, sz, sg, a, d}; st <= !ld && !cp;
        @(posedge clk);
        rqv <= 0;
        @(posedge clk);
        chk({31'h0, rspv}, 32'h1);
        if (ld) chk(lres, el);
        else chk(sw, es);
        chk({29'h0, aso}, {29'h0, sz});
        chk({30'h0, alo}, {30'h0, a});
        chk({30'h0, lp}, {30'h0, lp_e});
        for (int k = 0; k < 4; k++) begin
            if (!ld && !cp && (!en || (byt ? k == sel : hlf ? (k / 2) == hs : 1'b1)))
                mem_e[8*k +: 8] = es[8*k +: 8];
        end
    endtask : acc

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        axr(subword_align_pkg::OFS_CONFIG, r32, resp);
        chk(r32, 32'h0);
        axr(subword_align_pkg::OFS_STATUS, r32, resp);
        chk(r32, 32'h0);
        // Unmapped place refused both ways
        axw(4'h8, 32'hFFFFFFFF, resp);
        chk({30'h0, resp}, {30'h0, subword_align_pkg::RESP_DECERR});
        axr(4'h8, r32, resp);
        chk({r32[29:0], resp}, {30'h0, subword_align_pkg::RESP_DECERR});
        // Every order and freeze setting, every lane, both extensions
        for (int m = 0; m < 4; m++) begin
            cfg(1'b1, m[0], m[1]);
            acc(0, 0, 3'h0, 0, 2'h0, 32'h89ABC2F1);
            for (int a = 0; a < 4; a++) begin
                for (int s = 0; s < 2; s++) begin
                    acc(1, 0, 3'h1, s[0], a[1:0], 32'h0);
                    acc(1, 0, 3'h2, s[0], a[1:0], 32'h0);
                end
                acc(0, 0, 3'h1, 1, a[1:0], 32'h12345680 | a);
                acc(1, 0, 3'h0, 0, a[1:0], 32'h0);
            end
        end
        // Random mix, configuration changed now and then
        repeat (300) begin
            sd = xs(sd);
            if (sd[3:0] == 4'h0) cfg(sd[4], sd[5], sd[6]);
            sd = xs(sd);
            acc(sd[0], sd[3:1] == 3'h0, sd[4] ? sd[7:5] : {1'b0, sd[6:5] % 2'h3},
                sd[8], sd[10:9], xs(sd));
        end
        axr(subword_align_pkg::OFS_STATUS, r32, resp);
        chk(r32, {23'h0, lld, 1'b0, lsz, 2'h0, lp_e});
        test_done;
    end

    // Watchdog: the whole run needs some 1400 cycles, this allows far more
    initial begin
        #3000000;
        fails++;
        test_done;
    end
endmodule : subword_load_store_align_test
